// >>> verilog/i2cdm_consts.svh
`ifndef I2CDM_CONSTS_SVH
`define I2CDM_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define I2CDM_OFF_CTRL   12'h000
`define I2CDM_OFF_STAT   12'h004
`define I2CDM_OFF_DATA   12'h008
`define I2CDM_OFF_MODE   12'h00C

// ****************************************
// reset values
// ****************************************
`define I2CDM_CTRL_RST   8'h00
`define I2CDM_MODE_RST   8'h38
`define I2CDM_ADDR_RST   8'h00
`define I2CDM_RSVD_ONES  3'h7

// ****************************************
// field positions
// ****************************************
`define I2CDM_CTRL_EN    7
`define I2CDM_CTRL_GATE  6
`define I2CDM_CTRL_MST   5
`define I2CDM_CTRL_DIR   4
`define I2CDM_CTRL_ACK   3
`define I2CDM_MODE_ORDER 7
`define I2CDM_MODE_WAIT  6
`define I2CDM_STAT_FLAG  6

// ****************************************
// counts
// ****************************************
`define I2CDM_FULL_BYTE  4'h8
`define I2CDM_SCL_HALF   8

`endif

// >>> verilog/i2cdm_pkg.sv
package i2cdm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_DATA  = 2'h1,
        ST_WAITK = 2'h3,
        ST_ACK   = 2'h2
    } i2cdm_state_e;

    typedef enum logic [1:0] {
        MODE_SLV_RX = 2'h0,
        MODE_SLV_TX = 2'h1,
        MODE_MST_RX = 2'h2,
        MODE_MST_TX = 2'h3
    } i2cdm_mode_e;

endpackage

// >>> verilog/i2cdm_line_if.sv
`timescale 1ns/1ns

interface i2cdm_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic tick;

    modport sync (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport div  (output tick);
    modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det, tick);
endinterface

// >>> verilog/i2cdm_line_sync.sv
`timescale 1ns/1ns
`include "i2cdm_consts.svh"

module i2cdm_line_sync (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  scl_pin,
    input  wire logic  sda_pin,
    i2cdm_line_if.sync lk
);

    logic [2:0] scl_q;
    logic [2:0] sda_q;

    // ****************************************
    // two-stage sync plus history stage
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_pin};
            sda_q <= {sda_q[1:0], sda_pin};
        end
    end

    assign lk.scl       = scl_q[1];
    assign lk.sda       = sda_q[1];
    assign lk.scl_rise  = scl_q[1] & ~scl_q[2];
    assign lk.scl_fall  = ~scl_q[1] & scl_q[2];
    assign lk.start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign lk.stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

endmodule

// >>> verilog/i2cdm_tick_div.sv
`timescale 1ns/1ns

module i2cdm_tick_div #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    i2cdm_line_if.div lk
);

    logic [15:0] cnt;

    // ****************************************
    // half-period enable pulse
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt <= 16'h0000;
        end else if (cnt == 16'(HALF - 1)) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end

    assign lk.tick = run && (cnt == 16'(HALF - 1));

endmodule

// >>> verilog/i2cdm_top.sv
// Summary of operation
// R01: writing the data register starts a transmit frame
// R02: reading the data register starts the next receive frame
// R03: software leaves the data register alone while a frame runs
// R04: the data register has no reset value
// R05: addressed slave compares first byte upper 7 bits with own address
// R06: own address and frame mode share one offset, chosen by enable
// R07: own address bit 0 picks addressing or non-addressing slave format
// R08: frame mode bit 7 picks msb-first or lsb-first shifting
// R09: wait mode holds clock low after data until flag cleared
// R10: without wait, data and acknowledge run back to back
// R11: frame mode bits 5 to 3 ignore writes and read as one
// R12: frame count 000 means 8 bits, n means n, plus acknowledge
// R13: software changes frame count only between frames, clock low
// R14: bit counter clears on reset, start condition and frame end
// R15: enable drives the pins; disabled leaves them released and idle
// R16: control bit 6 gates the interrupt request
// R17: reset loads own address 00, frame mode 38, control 00
// R18: software gives a unique own address on the bus
// R19: master and direction bits encode the four operating modes
// R20: acknowledge mode bit adds or drops the acknowledge bit
// R21: non-addressing format skips compare and takes bytes as data
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "i2cdm_consts.svh"

module i2cdm_top #(
    parameter int SCL_HALF = `I2CDM_SCL_HALF
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    output logic             IRQ
);

    i2cdm_line_if line ();

    logic [7:0]                  ctrl;
    logic [6:0]                  own_addr;
    logic                        fmt_sel;
    logic                        order_lsb;
    logic                        wait_en;
    logic [2:0]                  bc;
    logic [7:0]                  sh;
    i2cdm_pkg::i2cdm_state_e     state;
    i2cdm_pkg::i2cdm_mode_e      mode;
    logic [3:0]                  bit_cnt;
    logic                        flag;
    logic                        armed;
    logic                        addr_phase;
    logic                        addressed;
    logic                        busy;
    logic                        ack_bit;
    logic                        scl_low;
    logic                        ready_q;
    logic                        en;
    logic                        is_master;
    logic                        ack_mode;
    logic                        is_tx;
    logic                        out_bit;
    logic                        match;
    logic                        last;
    logic                        data_done;
    logic                        frame_end;
    logic                        set_flag;
    logic                        go;
    logic                        ack_drive;
    logic [3:0]                  data_bits;
    logic                        apb_req;
    logic                        wr;
    logic                        rd;
    logic                        sel_ctrl;
    logic                        sel_stat;
    logic                        sel_data;
    logic                        sel_mode;
    logic                        mapped;
    logic                        sda_drive;

    // ****************************************
    // line sampling and master clock divider
    // ****************************************
    i2cdm_line_sync u_sync (
        .clk     (CLOCK),
        .rst     (RST),
        .scl_pin (SCL_IN),
        .sda_pin (SDA_IN),
        .lk      (line.sync)
    );

    i2cdm_tick_div #(.HALF(SCL_HALF)) u_div (
        .clk (CLOCK),
        .rst (RST),
        .run (is_master && (state == i2cdm_pkg::ST_DATA || state == i2cdm_pkg::ST_ACK)),
        .lk  (line.div)
    );

    // ****************************************
    // apb decode
    // ****************************************
    assign apb_req  = PSEL && PENABLE;
    assign wr       = apb_req && PREADY && PWRITE;
    assign rd       = apb_req && PREADY && !PWRITE;
    assign sel_ctrl = PADDR == `I2CDM_OFF_CTRL;
    assign sel_stat = PADDR == `I2CDM_OFF_STAT;
    assign sel_data = PADDR == `I2CDM_OFF_DATA;
    assign sel_mode = PADDR == `I2CDM_OFF_MODE;
    assign mapped   = sel_ctrl || sel_stat || sel_data || sel_mode;
    assign PREADY   = ready_q;
    assign PSLVERR  = apb_req && ready_q && !mapped;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= apb_req && !ready_q;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (apb_req && !ready_q && !PWRITE) begin
            PRDATA <= 32'h00000000;
            if (sel_ctrl) begin
                PRDATA[7:0] <= ctrl;
            end else if (sel_stat) begin
                PRDATA[7:0] <= {busy, flag, 3'h0, addressed, 1'b0, ack_bit};
            end else if (sel_data) begin
                PRDATA[7:0] <= sh;
            end else if (sel_mode && en) begin
                // R11: reserved bits read one
                PRDATA[7:0] <= {order_lsb, wait_en, `I2CDM_RSVD_ONES, bc};
            end else if (sel_mode) begin
                PRDATA[7:0] <= {own_addr, fmt_sel};
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************
    assign en        = ctrl[`I2CDM_CTRL_EN];
    // R19: mode encoding
    assign mode      = i2cdm_pkg::i2cdm_mode_e'({ctrl[`I2CDM_CTRL_MST], ctrl[`I2CDM_CTRL_DIR]});
    assign is_master = en && (mode == i2cdm_pkg::MODE_MST_RX || mode == i2cdm_pkg::MODE_MST_TX);
    // R20: acknowledge mode select
    assign ack_mode  = !ctrl[`I2CDM_CTRL_ACK];

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            // R17: control reset value
            ctrl <= `I2CDM_CTRL_RST;
        end else if (wr && sel_ctrl) begin
            ctrl <= PWDATA[7:0];
        end else if (data_done && addr_phase && match) begin
            ctrl[`I2CDM_CTRL_DIR] <= sh[0];
        end
    end

    // ****************************************
    // own address and frame mode, one offset
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            // R17: own address and mode reset values
            {own_addr, fmt_sel}          <= `I2CDM_ADDR_RST;
            {order_lsb, wait_en}         <= 2'(`I2CDM_MODE_RST >> 6);
            bc                           <= 3'h0;
        end else if (wr && sel_mode) begin
            // R06: enable picks the register behind the offset
            if (en) begin
                order_lsb <= PWDATA[`I2CDM_MODE_ORDER];
                wait_en   <= PWDATA[`I2CDM_MODE_WAIT];
                bc        <= PWDATA[2:0];
            end else begin
                {own_addr, fmt_sel} <= PWDATA[7:0];
            end
        end
    end

    // ****************************************
    // frame shape
    // ****************************************
    // R12: frame count decode
    assign data_bits = (bc == 3'h0) ? `I2CDM_FULL_BYTE : {1'b0, bc};
    assign last      = bit_cnt == data_bits;
    assign data_done = state == i2cdm_pkg::ST_DATA && line.scl_fall && last;
    assign frame_end = (state == i2cdm_pkg::ST_ACK && line.scl_fall) ||
                       (data_done && !ack_mode);
    assign is_tx     = !addr_phase && ctrl[`I2CDM_CTRL_DIR];
    // R08: bit order
    assign out_bit   = order_lsb ? sh[0] : sh[7];
    // R05: address compare
    assign match     = sh[7:1] == own_addr;
    assign ack_drive = !is_tx && (!addr_phase || match);
    // R07: format select gates slave participation
    // R21: non-addressing format takes bytes as data
    assign go        = (armed || addr_phase) &&
                       (is_master || addr_phase || addressed || fmt_sel);

    // ****************************************
    // transfer sequencer and bit counter
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (RST || !en || line.start_det || line.stop_det) begin
            // R14: counter clear on reset and start
            state   <= i2cdm_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                i2cdm_pkg::ST_IDLE: begin
                    if (go) begin
                        state   <= i2cdm_pkg::ST_DATA;
                        bit_cnt <= 4'h0;
                    end
                end
                i2cdm_pkg::ST_DATA: begin
                    if (line.scl_fall && last) begin
                        if (!ack_mode) begin
                            // R14: frame end clears counter
                            state   <= i2cdm_pkg::ST_IDLE;
                            bit_cnt <= 4'h0;
                        end else if (wait_en) begin
                            // R09: hold for software
                            state   <= i2cdm_pkg::ST_WAITK;
                        end else begin
                            // R10: straight into acknowledge
                            state   <= i2cdm_pkg::ST_ACK;
                        end
                    end else if (line.scl_rise) begin
                        // count data bits on the sampling edge
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                i2cdm_pkg::ST_WAITK: begin
                    // R09: flag clear ends wait
                    if (!flag) begin
                        state <= i2cdm_pkg::ST_ACK;
                    end
                end
                i2cdm_pkg::ST_ACK: begin
                    if (line.scl_fall) begin
                        // R14: acknowledge end clears counter
                        state   <= i2cdm_pkg::ST_IDLE;
                        bit_cnt <= 4'h0;
                    end
                end
                default: begin
                    state   <= i2cdm_pkg::ST_IDLE;
                    bit_cnt <= 4'h0;
                end
            endcase
        end
    end

    // ****************************************
    // shift data register
    // ****************************************
    // R04: no reset value
    always_ff @(posedge CLOCK) begin
        if (wr && sel_data) begin
            sh <= PWDATA[7:0];
        end else if (state == i2cdm_pkg::ST_DATA && line.scl_rise) begin
            // R08: shift direction
            sh <= order_lsb ? {line.sda, sh[7:1]} : {sh[6:0], line.sda};
        end
    end

    // ****************************************
    // arming and slave addressing
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (RST || !en) begin
            armed <= 1'b0;
        end else if (wr && sel_data) begin
            // R01: write starts transmit
            armed <= 1'b1;
        end else if (rd && sel_data) begin
            // R02: read starts receive
            armed <= 1'b1;
        end else if ((frame_end && !addr_phase) || line.start_det) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST || !en || line.stop_det) begin
            addr_phase <= 1'b0;
            addressed  <= 1'b0;
        end else if (line.start_det) begin
            // R05: slave addressing format collects the address byte
            addr_phase <= !is_master && !fmt_sel;
            addressed  <= 1'b0;
        end else if (data_done && addr_phase) begin
            addressed  <= match;
        end else if (frame_end) begin
            addr_phase <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            busy    <= 1'b0;
            ack_bit <= 1'b0;
        end else begin
            if (line.start_det) begin
                busy <= 1'b1;
            end else if (line.stop_det) begin
                busy <= 1'b0;
            end
            if (state == i2cdm_pkg::ST_ACK && line.scl_rise && is_tx) begin
                ack_bit <= line.sda;
            end
        end
    end

    // ****************************************
    // transfer flag, set wins over clear
    // ****************************************
    assign set_flag = (data_done && ack_mode && wait_en && (!addr_phase || match)) ||
                      (frame_end && !(ack_mode && wait_en) && (!addr_phase || addressed));

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            flag <= 1'b0;
        end else if (set_flag) begin
            flag <= 1'b1;
        end else if (wr && sel_stat && !PWDATA[`I2CDM_STAT_FLAG]) begin
            flag <= 1'b0;
        end
    end

    // R16: interrupt gate
    assign IRQ = flag && ctrl[`I2CDM_CTRL_GATE];

    // ****************************************
    // pin drive
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (RST || !is_master || state == i2cdm_pkg::ST_IDLE) begin
            scl_low <= 1'b0;
        end else if (state == i2cdm_pkg::ST_WAITK) begin
            scl_low <= 1'b1;
        end else if (line.tick) begin
            scl_low <= !scl_low;
        end
    end

    // R15: pins released while disabled
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE  = en && (state == i2cdm_pkg::ST_WAITK || scl_low);
    assign SDA_OE  = en && sda_drive;

    // data line moves only while clock is low
    always_ff @(posedge CLOCK) begin
        if (RST || !en) begin
            sda_drive <= 1'b0;
        end else if (!line.scl) begin
            sda_drive <= (state == i2cdm_pkg::ST_DATA && is_tx && !out_bit) ||
                         (state == i2cdm_pkg::ST_ACK && ack_drive);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_data_done;
        state == i2cdm_pkg::ST_DATA && line.scl_fall && last;
    endsequence

    sequence s_addr_hit;
        s_data_done ##0 addr_phase && match;
    endsequence

    a_pins_released: // R15
        assert property (!en |-> !SCL_OE && !SDA_OE)
        else $error("pins driven while disabled");
    a_irq_gate: // R16
        assert property ($rose(flag) && ctrl[`I2CDM_CTRL_GATE] |-> IRQ ##0 !$past(IRQ))
        else $error("interrupt gate wrong");
    a_wait_hold: // R09
        assert property (s_data_done ##0 ack_mode && wait_en |=>
                         state == i2cdm_pkg::ST_WAITK && flag && SCL_OE)
        else $error("wait not entered");
    a_wait_release: // R09
        assert property (state == i2cdm_pkg::ST_WAITK && !flag && en |=>
                         state == i2cdm_pkg::ST_ACK)
        else $error("wait not released");
    a_no_wait: // R10
        assert property (s_data_done ##0 ack_mode && !wait_en |=> state == i2cdm_pkg::ST_ACK)
        else $error("wait inserted");
    a_count_clear: // R14
        assert property (line.start_det |=> bit_cnt == 4'h0 && state == i2cdm_pkg::ST_IDLE)
        else $error("counter not cleared");
    a_frame_len: // R12
        assert property (state == i2cdm_pkg::ST_DATA && line.scl_rise |-> bit_cnt < data_bits)
        else $error("frame length overrun");
    a_write_arm: // R01
        assert property (wr && sel_data && en |=> armed && sh == $past(PWDATA[7:0]))
        else $error("write did not arm");
    a_read_arm: // R02
        assert property (rd && sel_data && en |=> armed)
        else $error("read did not arm");
    a_mode_ones: // R11
        assert property (apb_req && ready_q && !PWRITE && sel_mode && en |->
                         PRDATA[5:3] == `I2CDM_RSVD_ONES)
        else $error("reserved bits not one");
    a_reset_load: // R17
        assert property ($past(RST) |-> ctrl == `I2CDM_CTRL_RST && own_addr == 7'h00 &&
                         {order_lsb, wait_en, bc} == 5'h00)
        else $error("reset values wrong");
    a_addr_hit: // R05
        assert property (s_addr_hit |=> addressed ##0 ctrl[`I2CDM_CTRL_DIR] == $past(sh[0]))
        else $error("address match ignored");

endmodule

// >>> sim/i2cdm_bus_peer.sv
`timescale 1ns/1ns
// ****
// far-side slave on the bus
// ****
module i2cdm_bus_peer (
    input  wire logic        scl,
    input  wire logic        sda,
    input  wire logic        clr,
    input  wire logic [4:0]  ack_at,
    output logic             sda_oe,
    output logic [4:0]       cnt,
    output logic [15:0]      bits
);
    initial sda_oe = 1'b0;
    always @(posedge scl or posedge clr) begin
        if (clr) begin
            cnt  <= 5'h00;
            bits <= 16'h0000;
        end else begin
            cnt  <= cnt + 5'h01;
            bits <= {bits[14:0], sda};
        end
    end
    // pull data low in the acknowledge bit only
    always @(negedge scl) begin
        sda_oe <= (cnt == ack_at - 5'h01);
    end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ns
// ****
// bench
// ****
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        scl_o;
    logic        scl_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        irq;
    logic        p_oe;
    logic        clr = 1'b1;
    logic [4:0]  ack_at = 5'h09;
    logic [4:0]  cnt;
    logic [15:0] bits;
    logic [31:0] rd;
    int          failures = 0;
    int          num_checks = 0;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | p_oe);

    always #20 clk = ~clk;

    i2cdm_top #(.SCL_HALF(4)) dut_u (.CLOCK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .SCL_IN(scl), .SCL_OUT(scl_o),
        .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .IRQ(irq));
    i2cdm_bus_peer peer_u (.scl(scl), .sda(sda), .clr(clr), .ack_at(ack_at),
        .sda_oe(p_oe), .cnt(cnt), .bits(bits));

    task automatic complete_run();
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = {31'h0, perr} ^ prd;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic chk_rd(input string s, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(s, e, rd)
    endtask

    task automatic start(input logic [7:0] d, input logic [4:0] a);
        ack_at <= a;
        clr    <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        apb(1'b1, 12'h008, {24'h0, d});
    endtask

    // data register left alone until the interrupt rises
    task automatic frame(input logic [7:0] d, input logic [4:0] a);
        int n = 0;
        start(d, a);
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK("irq", 1'b1, irq)
    endtask

    task automatic clr_flag();
        apb(1'b1, 12'h004, 32'h0);
        @(posedge clk);
        `CHK("irq clear", 1'b0, irq)
    endtask

    task automatic t_regs();
        chk_rd("ctrl", 12'h000, 32'h00);
        chk_rd("own", 12'h00C, 32'h00);
        apb(1'b1, 12'h000, 32'h80);
        chk_rd("mode", 12'h00C, 32'h38);
        apb(1'b1, 12'h00C, 32'h00);
        chk_rd("mode rsvd", 12'h00C, 32'h38);
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h00C, 32'hA5);
        apb(1'b1, 12'h000, 32'h80);
        chk_rd("shared mode", 12'h00C, 32'h38);
        apb(1'b1, 12'h000, 32'h00);
        chk_rd("shared own", 12'h00C, 32'hA5);
        chk_rd("unmapped", 12'h010, 32'h1);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h000, 32'h80 | (m << 4));
            chk_rd("op mode", 12'h000, 32'h80 | (m << 4));
        end
    endtask

    task automatic t_frames();
        int n = 0;
        apb(1'b1, 12'h000, 32'hF0);
        apb(1'b1, 12'h00C, 32'h00);
        frame(8'hA6, 5'h09);
        `CHK("tx count", 5'h09, cnt)
        `CHK("tx bits", 9'h14C, bits[8:0])
        chk_rd("flag", 12'h004, 32'h40);
        clr_flag();
        apb(1'b1, 12'h000, 32'hF8);
        apb(1'b1, 12'h00C, 32'h83);
        frame(8'h05, 5'h00);
        `CHK("lsb count", 5'h03, cnt)
        `CHK("lsb bits", 3'h5, bits[2:0])
        clr_flag();
        apb(1'b1, 12'h000, 32'hF0);
        apb(1'b1, 12'h00C, 32'h40);
        frame(8'h3C, 5'h09);
        repeat (16) @(posedge clk);
        `CHK("wait count", 5'h08, cnt)
        `CHK("wait scl", 1'b0, scl)
        clr_flag();
        while (cnt !== 5'h09 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK("ack count", 5'h09, cnt)
        `CHK("ack after wait", 9'h078, bits[8:0])
        repeat (40) @(posedge clk);
    endtask

    task automatic t_gate_off();
        apb(1'b1, 12'h000, 32'hB0);
        apb(1'b1, 12'h00C, 32'h00);
        start(8'h5A, 5'h09);
        repeat (200) @(posedge clk);
        `CHK("gated irq", 1'b0, irq)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("gated flag", 1'b1, rd[6])
        apb(1'b1, 12'h000, 32'h00);
        repeat (4) @(posedge clk);
        `CHK("pins off", 2'b00, {scl_oe, sda_oe})
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        clr <= 1'b0;
        t_regs();
        t_frames();
        t_gate_off();
        complete_run();
    end

    initial begin
        #400000;
        failures++;
        complete_run();
    end
endmodule
